// *** verilog/spdt_defs.vh ***
`ifndef SPDT_DEFS_VH
`define SPDT_DEFS_VH

// Function preambles, slave address bits 7..4
`define SPDT_PRE_SENSOR   4'h3
`define SPDT_PRE_EEPROM   4'ha
`define SPDT_PRE_UTILITY  4'h6

// Utility encodings, slave address bits 3..0
`define SPDT_UT_SET0      4'h2
`define SPDT_UT_SET1      4'h8
`define SPDT_UT_SET2      4'ha
`define SPDT_UT_SET3      4'h0
`define SPDT_UT_CLR       4'h6
`define SPDT_UT_QRY0      4'h3
`define SPDT_UT_QRY1      4'h9
`define SPDT_UT_QRY2      4'hb
`define SPDT_UT_QRY3      4'h1
`define SPDT_UT_BANK0     4'hc
`define SPDT_UT_BANK1     4'he
`define SPDT_UT_BANKQ     4'hd

// Reset and power-up values
`define SPDT_PTR_RESET    8'h00
`define SPDT_ERASED_BYTE  8'hff
`define SPDT_PROT_RESET   4'h0

// Page buffer geometry
`define SPDT_PAGE_BYTES   16
`define SPDT_POS_BITS     4

// Programming cycle time
`define SPDT_TWR_NS       5000000
`define SPDT_MCLK_NS      25

`endif

// *** verilog/spdt_sync.v ***
`timescale 1ns/1ps
`default_nettype none

module spdt_sync
(
    input  wire mclk,
    input  wire rst_b,
    input  wire pinIn,
    output reg  pinSync
);

    reg stage;

    // Pins idle high on an open-drain bus
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stage   <= 1'b1;
            pinSync <= 1'b1;
        end
        else
        begin
            stage   <= pinIn;
            pinSync <= stage;
        end
    end

endmodule

`default_nettype wire

// *** verilog/spdt_page_buf.v ***
`timescale 1ns/1ps
`default_nettype none
`include "spdt_defs.vh"

module spdt_page_buf
(
    input  wire       mclk,
    input  wire       rst_b,
    input  wire       clear,
    input  wire       wrEn,
    input  wire [3:0] wrPos,
    input  wire [7:0] wrData,
    input  wire [3:0] rdPos,
    output wire [7:0] rdData,
    output wire       rdValid
);

    reg [7:0]  slot [0:`SPDT_PAGE_BYTES-1];
    reg [15:0] loaded;

    genvar g;
    generate
        for (g = 0; g < `SPDT_PAGE_BYTES; g = g + 1)
        begin : gSlot
            always @(posedge mclk or negedge rst_b)
            begin
                if (!rst_b)
                    slot[g] <= `SPDT_ERASED_BYTE;
                else if (wrEn && wrPos == g)
                    slot[g] <= wrData;
            end
        end
    endgenerate

    // Only bytes loaded in this frame are programmed; later bytes replace earlier
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            loaded <= 16'h0000;
        else if (clear)
            loaded <= 16'h0000;
        else if (wrEn)
            loaded <= loaded | (16'h0001 << wrPos);
    end

    assign rdData  = slot[rdPos];
    assign rdValid = loaded[rdPos];

endmodule

`default_nettype wire

// *** verilog/spdt_slave.v ***
`timescale 1ns/1ps
`default_nettype none
`include "spdt_defs.vh"

// Summary of operation
// R1: SDA fall with SCL high is start
// R2: SDA rise with SCL high is stop
// R3: Ignore everything until a start arrives
// R4: Change SDA only while SCL is low
// R5: Master starts idle bus with address
// R6: Bits 7..4 choose sensor, EEPROM or utility
// R7: Bits 3..1 must match select pins
// R8: Acknowledge matching address and written bytes; code acks sensor and EEPROM addresses only with bit 0 low
// R9: Stop sending after master no-acknowledge
// R10: Decode the utility command set
// R11: No high voltage: no-acknowledge third byte
// R12: Master holds pin zero steady meanwhile
// R13: Both pointers reset to zero
// R14: One bank active; lower after reset
// R15: Write takes address then one/two bytes
// R16: Stop commits sensor write or programs EEPROM
// R17: Sixteen pages of sixteen bytes each
// R18: Byte position wraps within page buffer
// R19: Busy programming: do not acknowledge address
// R20: Master polls with address until acknowledged
// R21: Delivered unprotected, all bytes erased
// R22: Drive low for zero, release for one
// R23: Bank query acknowledges when lower bank
// R24: Protect query no-acknowledges when protected
// R25: Blocks are bank halves, individually protected
// R26: Reserved utility codes get no acknowledge
// R27: Protected block writes are discarded
module spdt_slave
#(
    parameter TWR_CYCLES = `SPDT_TWR_NS / `SPDT_MCLK_NS
)
(
    input  wire        mclk,
    input  wire        rst_b,
    input  wire        sclPin,
    input  wire        sdaIn,
    output reg         sdaOut,
    output reg         sdaOe,
    input  wire        addrSelectPinZero,
    input  wire        addrSelectPinOne,
    input  wire        addrSelectPinTwo,
    input  wire        veryHighVoltageLevel,
    output reg  [7:0]  sensorPointer,
    output reg  [15:0] sensorWriteData,
    output reg         sensorWriteStrobe,
    output reg  [7:0]  eepromPointer,
    output reg         activeBank,
    output reg  [3:0]  protectFlags,
    output reg         eepromBusy,
    output reg         eepromProgStrobe,
    output reg  [8:0]  eepromProgAddr,
    output reg  [7:0]  eepromProgData
);

    localparam ST_IDLE = 6'h01;
    localparam ST_ADDR = 6'h02;
    localparam ST_ACK  = 6'h04;
    localparam ST_RECV = 6'h08;
    localparam ST_SEND = 6'h10;
    localparam ST_PROG = 6'h20;

    localparam CMD_NONE   = 3'h0;
    localparam CMD_SENSOR = 3'h1;
    localparam CMD_EEPROM = 3'h2;
    localparam CMD_PROT   = 3'h3;
    localparam CMD_CLEAR  = 3'h4;
    localparam CMD_BANK   = 3'h5;

    wire scl;
    wire sda;
    wire vhv;
    reg  sensorFull;
    reg  sclPrev;
    reg  sdaPrev;
    reg  [5:0] state;
    reg  [3:0] bitCount;
    reg  [7:0] shift;
    reg  [1:0] byteCount;
    reg  [2:0] cmd;
    reg  [1:0] cmdBlock;
    reg  cmdBank;
    reg  ackNow;
    reg  ackTaken;
    reg  hvOk;
    reg  [3:0] pos;
    reg  [3:0] pageBase;
    reg  bufWr;
    reg  bufClear;
    reg  [4:0] progIdx;
    reg  [23:0] twrCount;
    wire [7:0] bufRd;
    wire bufValid;

    spdt_sync uSyncScl (.mclk(mclk), .rst_b(rst_b), .pinIn(sclPin), .pinSync(scl));
    spdt_sync uSyncSda (.mclk(mclk), .rst_b(rst_b), .pinIn(sdaIn), .pinSync(sda));
    spdt_sync uSyncHv  (.mclk(mclk), .rst_b(rst_b), .pinIn(veryHighVoltageLevel),
                        .pinSync(vhv));

    spdt_page_buf uBuf
    (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .clear   (bufClear),
        .wrEn    (bufWr),
        .wrPos   (pos),
        .wrData  (shift),
        .rdPos   (progIdx[3:0]),
        .rdData  (bufRd),
        .rdValid (bufValid)
    );

    wire startCond = sclPrev && scl && sdaPrev && !sda;   // see R1
    wire stopCond  = sclPrev && scl && !sdaPrev && sda;   // see R2
    wire sclRise   = !sclPrev && scl;
    wire sclFall   = sclPrev && !scl;
    wire [2:0] pinSel = {addrSelectPinTwo, addrSelectPinOne, addrSelectPinZero};

    // Bank picks blocks 0/1 or 2/3, byte bit 7 the half
    function [1:0] blockOf;
        input       bank;
        input [7:0] byteAddr;
        begin
            blockOf = {bank, byteAddr[7]};   // see R25
        end
    endfunction

    // Utility low nibble to block number for set and query
    function [1:0] utilBlock;
        input [3:0] code;
        begin
            case (code[3:1])
                3'h1:    utilBlock = 2'd0;
                3'h4:    utilBlock = 2'd1;
                3'h5:    utilBlock = 2'd2;
                default: utilBlock = 2'd3;
            endcase
        end
    endfunction

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end
        else
        begin
            sclPrev <= scl;
            sdaPrev <= sda;
        end
    end

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state             <= ST_IDLE;
            bitCount          <= 4'h0;
            shift             <= 8'h00;
            byteCount         <= 2'h0;
            cmd               <= CMD_NONE;
            cmdBlock          <= 2'h0;
            cmdBank           <= 1'b0;
            ackNow            <= 1'b0;
            ackTaken          <= 1'b0;
            hvOk              <= 1'b0;
            sensorFull        <= 1'b0;
            pos               <= 4'h0;
            pageBase          <= 4'h0;
            bufWr             <= 1'b0;
            bufClear          <= 1'b0;
            progIdx           <= 5'h00;
            twrCount          <= 24'h000000;
            sdaOut            <= 1'b1;
            sdaOe             <= 1'b0;
            sensorPointer     <= `SPDT_PTR_RESET;     // see R13
            eepromPointer     <= `SPDT_PTR_RESET;     // see R13
            sensorWriteData   <= 16'h0000;
            sensorWriteStrobe <= 1'b0;
            activeBank        <= 1'b0;                // see R14
            protectFlags      <= `SPDT_PROT_RESET;    // see R21
            eepromBusy        <= 1'b0;
            eepromProgStrobe  <= 1'b0;
            eepromProgAddr    <= 9'h000;
            eepromProgData    <= 8'h00;
        end
        else
        begin
            bufWr             <= 1'b0;
            bufClear          <= 1'b0;
            sensorWriteStrobe <= 1'b0;
            eepromProgStrobe  <= 1'b0;
            if (state == ST_PROG)
            begin
                // The bus is ignored while busy, so polling sees no ack
                sdaOe  <= 1'b0;                       // see R19
                sdaOut <= 1'b1;
                if (progIdx < 5'd16)
                begin
                    if (bufValid)
                    begin
                        eepromProgStrobe <= 1'b1;     // see R17
                        eepromProgAddr   <= {activeBank, pageBase, progIdx[3:0]};
                        eepromProgData   <= bufRd;
                    end
                    progIdx <= progIdx + 5'd1;
                end
                else if (twrCount == 24'h000000)
                begin
                    eepromBusy <= 1'b0;
                    state      <= ST_IDLE;
                end
                else
                    twrCount <= twrCount - 24'd1;
            end
            else if (startCond)
            begin
                state    <= ST_ADDR;                  // see R1
                bitCount <= 4'h0;
                byteCount <= 2'h0;
                hvOk     <= vhv;
                sensorFull <= 1'b0;
                sdaOe    <= 1'b0;
                bufClear <= 1'b1;
            end
            else if (stopCond)
            begin
                sdaOe <= 1'b0;                        // see R2
                state <= ST_IDLE;
                if (cmd == CMD_SENSOR && sensorFull)
                    sensorWriteStrobe <= 1'b1;        // see R16
                else if (cmd == CMD_EEPROM && byteCount == 2'd3
                         && !protectFlags[blockOf(activeBank, {pageBase, 4'h0})])
                begin
                    // Protected data never starts a cycle
                    state      <= ST_PROG;            // see R16 R27
                    eepromBusy <= 1'b1;
                    progIdx    <= 5'h00;
                    twrCount   <= TWR_CYCLES[23:0];
                end
                cmd <= CMD_NONE;
            end
            else if (state == ST_ADDR || state == ST_RECV)
            begin
                if (sclRise)                          // see R4
                begin
                    shift    <= {shift[6:0], sda};
                    bitCount <= bitCount + 4'd1;
                end
                else if (sclFall && bitCount == 4'd8)
                begin
                    bitCount <= 4'h0;
                    state    <= ST_ACK;
                    ackNow   <= 1'b0;
                    if (state == ST_ADDR)
                    begin
                        cmd      <= CMD_NONE;
                        cmdBlock <= utilBlock(shift[3:0]);
                        byteCount <= 2'd1;
                        case (shift[7:4])             // see R6
                            `SPDT_PRE_SENSOR:
                                if (shift[3:1] == pinSel)         // see R7
                                begin
                                    cmd    <= CMD_SENSOR;
                                    ackNow <= !shift[0];          // see R8
                                end
                            `SPDT_PRE_EEPROM:
                                if (shift[3:1] == pinSel)         // see R7
                                begin
                                    cmd    <= CMD_EEPROM;
                                    ackNow <= !shift[0];          // see R8
                                end
                            `SPDT_PRE_UTILITY:
                                case (shift[3:0])                 // see R10
                                    `SPDT_UT_SET0, `SPDT_UT_SET1,
                                    `SPDT_UT_SET2, `SPDT_UT_SET3:
                                    begin
                                        cmd    <= CMD_PROT;
                                        ackNow <= !protectFlags[utilBlock(shift[3:0])];
                                    end
                                    `SPDT_UT_CLR:
                                    begin
                                        cmd    <= CMD_CLEAR;
                                        ackNow <= 1'b1;
                                    end
                                    `SPDT_UT_QRY0, `SPDT_UT_QRY1,
                                    `SPDT_UT_QRY2, `SPDT_UT_QRY3:
                                        ackNow <= !protectFlags[utilBlock(shift[3:0])]; // see R24
                                    `SPDT_UT_BANK0, `SPDT_UT_BANK1:
                                    begin
                                        cmd     <= CMD_BANK;
                                        cmdBank <= shift[1];
                                        ackNow  <= 1'b1;
                                    end
                                    `SPDT_UT_BANKQ:
                                        ackNow <= !activeBank;    // see R23
                                    default:
                                        ackNow <= 1'b0;           // see R26
                                endcase
                            default:
                                ackNow <= 1'b0;
                        endcase
                    end
                    else
                    begin
                        // Count bytes after the address
                        if (byteCount != 2'd3)
                            byteCount <= byteCount + 2'd1;
                        case (cmd)
                            CMD_SENSOR:
                            begin
                                ackNow <= 1'b1;           // see R15
                                if (byteCount == 2'd1)
                                    sensorPointer <= shift;
                                else if (byteCount == 2'd2)
                                    sensorWriteData[15:8] <= shift;
                                else
                                begin
                                    sensorWriteData[7:0] <= shift;
                                    sensorFull           <= 1'b1;
                                end
                            end
                            CMD_EEPROM:
                            begin
                                ackNow <= 1'b1;           // see R8 R15
                                if (byteCount == 2'd1)
                                begin
                                    eepromPointer <= shift;
                                    pageBase      <= shift[7:4];
                                    pos           <= shift[3:0];
                                end
                                else
                                    bufWr <= 1'b1;
                            end
                            CMD_PROT, CMD_CLEAR:
                                // Third byte refused without high voltage
                                ackNow <= (byteCount == 2'd2) ? hvOk : 1'b1; // see R11
                            CMD_BANK:
                                ackNow <= (byteCount != 2'd2);
                            default:
                                ackNow <= 1'b0;
                        endcase
                    end
                end
            end
            else if (state == ST_ACK)
            begin
                // Drive only while SCL is low
                if (!scl && !sdaOe && ackNow && !ackTaken)
                begin
                    sdaOe    <= 1'b1;                 // see R8 R22
                    sdaOut   <= 1'b0;
                    ackTaken <= 1'b1;
                end
                else if (sclFall)
                begin
                    sdaOe    <= 1'b0;
                    sdaOut   <= 1'b1;
                    ackTaken <= 1'b0;
                    if (bufWr == 1'b0 && cmd == CMD_EEPROM && byteCount >= 2'd3)
                        pos <= pos + 4'd1;            // see R18
                    if (!ackNow)
                        state <= ST_IDLE;             // see R3 R9
                    else
                    begin
                        state <= ST_RECV;
                        if (cmd == CMD_PROT && byteCount == 2'd3)
                            protectFlags[cmdBlock] <= 1'b1;
                        else if (cmd == CMD_CLEAR && byteCount == 2'd3)
                            protectFlags <= 4'h0;
                        else if (cmd == CMD_BANK && byteCount == 2'd2)
                            activeBank <= cmdBank;    // see R14
                    end
                end
            end
        end
    end

endmodule

`default_nettype wire

// *** test/spdt_slave_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module spdt_slave_sva
#(
    parameter TWR_CYCLES = 50
)
(
    input wire       mclk,
    input wire       rst_b,
    input wire       sclPin,
    input wire       sdaIn,
    input wire       sdaOut,
    input wire       sdaOe,
    input wire       veryHighVoltageLevel,
    input wire [7:0] sensorPointer,
    input wire       sensorWriteStrobe,
    input wire [7:0] eepromPointer,
    input wire       activeBank,
    input wire [3:0] protectFlags,
    input wire       eepromBusy,
    input wire       eepromProgStrobe,
    input wire [8:0] eepromProgAddr
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    logic [15:0] busyCnt;
    // Bounds programming time without long repetitions
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            busyCnt <= 16'h0000;
        else if (eepromBusy)
            busyCnt <= busyCnt + 16'h0001;
        else
            busyCnt <= 16'h0000;
    end
    sequence s_ackHold;
        sdaOe [*6];
    endsequence
    sequence s_stopLevels;
        sclPin && sdaIn;
    endsequence
    a_drive_low: assert property (sdaOe |-> !sdaOut)
        else $error("SDA driven high by device");
    a_ack_edges: assert property (($rose(sdaOe) || $fell(sdaOe)) |-> !sclPin)
        else $error("SDA drive changed while SCL high");
    a_ack_stands: assert property ($rose(sdaOe) |-> s_ackHold ##[1:8] !sdaOe)
        else $error("acknowledge pulse has wrong length");
    a_busy_nack: assert property ($rose(sdaOe) |-> !eepromBusy)
        else $error("acknowledge given while programming");
    a_strobe_stop: assert property (sensorWriteStrobe |-> s_stopLevels ##1 !sensorWriteStrobe)
        else $error("sensor strobe outside stop or too long");
    a_prog_bank: assert property (eepromProgStrobe |-> eepromBusy && eepromProgAddr[8] == activeBank)
        else $error("programming outside busy or wrong bank");
    a_busy_span: assert property ($fell(eepromBusy) |-> busyCnt >= TWR_CYCLES && busyCnt <= TWR_CYCLES + 64)
        else $error("programming time out of range");
    a_flags_hv: assert property ($changed(protectFlags) |-> veryHighVoltageLevel)
        else $error("protect flags changed without high voltage");
    a_reset_init: assert property ($rose(rst_b) |-> sensorPointer == 8'h00 && eepromPointer == 8'h00
                                   && !activeBank && protectFlags == 4'h0)
        else $error("wrong state after reset");
endmodule
bind spdt_slave spdt_slave_sva #(.TWR_CYCLES(TWR_CYCLES)) spdt_slave_sva_i (.mclk, .rst_b,
    .sclPin, .sdaIn, .sdaOut, .sdaOe, .veryHighVoltageLevel, .sensorPointer,
    .sensorWriteStrobe, .eepromPointer, .activeBank, .protectFlags, .eepromBusy,
    .eepromProgStrobe, .eepromProgAddr);
`default_nettype wire

// *** test/spdt_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module spdt_host
(
    input  wire logic mclk,
    output var logic  scl,
    output var logic  sdaM,
    input  wire logic sdaWire
);
    // Idle bus: both lines released, SCL stands still between frames
    initial
    begin
        scl = 1'b1;
        sdaM = 1'b1;
    end
    task automatic q(input int n);
        repeat (2 * n) @(posedge mclk);
        #1;
    endtask
    task automatic start_c();
        q(2);
        sdaM = 1'b0;
        q(2);
    endtask
    task automatic stop_c();
        scl = 1'b0;
        q(1);
        sdaM = 1'b0;
        q(1);
        scl = 1'b1;
        q(2);
        sdaM = 1'b1;
        q(4);
    endtask
    task automatic put_byte(input logic [7:0] d, output logic ack);
        int i;
        for (i = 7; i >= -1; i--)
        begin
            scl = 1'b0;
            q(1);
            sdaM = (i < 0) ? 1'b1 : d[i];
            q(2);
            scl = 1'b1;
            q(1);
            // Long low phase covers the slave's sync lag
            if (i < 0)
                ack = (sdaWire === 1'b0);
        end
    endtask
endmodule
`default_nettype wire

// *** test/spdt_slave_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "spdt_defs.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module spdt_slave_tb;
    localparam   TWR = 400;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic        hv = 1'b0;
    logic [2:0]  selPins = 3'h0;
    logic        scl;
    logic        sdaM;
    logic        sdaOut;
    logic        sdaOe;
    wire         sdaWire = (sdaOe ? sdaOut : 1'b1) & sdaM;
    logic [7:0]  sensorPointer;
    logic [15:0] sensorWriteData;
    logic        sensorWriteStrobe;
    logic [7:0]  eepromPointer;
    logic        activeBank;
    logic [3:0]  protectFlags;
    logic        eepromBusy;
    logic        eepromProgStrobe;
    logic [8:0]  eepromProgAddr;
    logic [7:0]  eepromProgData;
    int          seed = 34138;
    int          error_cnt = 0;
    int          num_checks = 0;
    int          sStb = 0;
    int          pStb = 0;
    int          i;
    int          k;
    logic [7:0]  progMem [0:511];
    logic [7:0]  bq [$];
    logic [31:0] acks;
    logic [7:0]  bad [0:3];
    logic [3:0]  rsv [0:3] = '{4'h4, 4'h5, 4'h7, 4'hf};
    logic [3:0]  setc [0:3] = '{`SPDT_UT_SET0, `SPDT_UT_SET1, `SPDT_UT_SET2, `SPDT_UT_SET3};
    logic [3:0]  qryc [0:3] = '{`SPDT_UT_QRY0, `SPDT_UT_QRY1, `SPDT_UT_QRY2, `SPDT_UT_QRY3};
    always #12.5 mclk = ~mclk;
    spdt_slave #(.TWR_CYCLES(TWR)) spdt_slave_i (.mclk, .rst_b, .sclPin(scl), .sdaIn(sdaWire),
        .sdaOut, .sdaOe, .addrSelectPinZero(selPins[0]), .addrSelectPinOne(selPins[1]),
        .addrSelectPinTwo(selPins[2]), .veryHighVoltageLevel(hv), .sensorPointer,
        .sensorWriteData, .sensorWriteStrobe, .eepromPointer, .activeBank, .protectFlags,
        .eepromBusy, .eepromProgStrobe, .eepromProgAddr, .eepromProgData);
    spdt_host spdt_host_i (.mclk, .scl, .sdaM, .sdaWire);
    always @(posedge mclk)
    begin
        if (sensorWriteStrobe === 1'b1)
            sStb++;
        if (eepromProgStrobe === 1'b1)
        begin
            pStb++;
            progMem[eepromProgAddr] = eepromProgData;
        end
    end
    function automatic logic [7:0] adr(input logic [3:0] pre, input logic rw);
        return {pre, selPins, rw};
    endfunction
    function automatic logic [7:0] ut(input logic [3:0] c);
        return {`SPDT_PRE_UTILITY, c};
    endfunction
    task automatic xfer(input logic st, input logic wt);
        logic a;
        int   w;
        acks = 32'h0;
        if (st)
            spdt_host_i.start_c();
        foreach (bq[j])
        begin
            spdt_host_i.put_byte(bq[j], a);
            acks[j] = a;
        end
        spdt_host_i.stop_c();
        for (w = 0; w < 3000 && wt && eepromBusy !== 1'b0; w++)
            @(posedge mclk);
        #1;
    endtask
    task automatic page_wr(input logic bank, input int n);
        logic [7:0]  a;
        logic [7:0]  d [0:15];
        logic [15:0] hit;
        int          j;
        a = 8'($random(seed));
        hit = 16'h0000;
        bq = {adr(`SPDT_PRE_EEPROM, 1'b0), a};
        for (j = 0; j < n; j++)
        begin
            bq.push_back(8'($random(seed)));
            d[(a[3:0] + j) % 16] = bq[j + 2];
            hit[(a[3:0] + j) % 16] = 1'b1;
        end
        pStb = 0;
        xfer(1'b1, 1'b0);
        `CHK(acks, (32'h1 << (n + 2)) - 32'h1)
        `CHK(eepromBusy, 1'b1)
        bq = {adr(`SPDT_PRE_EEPROM, 1'b0)};
        xfer(1'b1, 1'b1);
        `CHK(acks[0], 1'b0)
        `CHK(eepromBusy, 1'b0)
        `CHK(pStb, (n < 16) ? n : 16)
        `CHK(eepromPointer, a)
        for (j = 0; j < 16; j++)
            if (hit[j])
                `CHK(progMem[{bank, a[7:4], j[3:0]}], d[j])
        xfer(1'b1, 1'b0);
        `CHK(acks[0], 1'b1)
    endtask
    task automatic stop_test();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge mclk);
        error_cnt++;
        stop_test();
    end
    initial
    begin
        // Straps fixed for the run
        selPins = 3'($random(seed));
        repeat (6) @(posedge mclk);
        #1;
        rst_b = 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        `CHK(sensorPointer, 8'h00)
        `CHK(eepromPointer, 8'h00)
        `CHK(activeBank, 1'b0)
        `CHK(protectFlags, 4'h0)
        bq = {adr(`SPDT_PRE_SENSOR, 1'b0), 8'h05, 8'h12, 8'h34};
        xfer(1'b0, 1'b0);
        `CHK(acks[3:0], 4'h0)
        `CHK(sStb, 0)
        bq = {adr(`SPDT_PRE_SENSOR, 1'b0), 8'($random(seed)), 8'($random(seed)),
              8'($random(seed))};
        xfer(1'b1, 1'b0);
        `CHK(acks[3:0], 4'hf)
        `CHK(sStb, 1)
        `CHK(sensorPointer, bq[1])
        `CHK(sensorWriteData, {bq[2], bq[3]})
        bq.pop_back();
        xfer(1'b1, 1'b0);
        `CHK(sStb, 1)
        bad = '{{`SPDT_PRE_SENSOR, selPins ^ 3'h1, 1'b0}, {4'h5, selPins, 1'b0},
                {`SPDT_PRE_EEPROM, selPins, 1'b1}, {`SPDT_PRE_EEPROM, selPins ^ 3'h4, 1'b0}};
        for (i = 0; i < 4; i++)
        begin
            bq = {bad[i], 8'h00};
            xfer(1'b1, 1'b0);
            `CHK(acks[1:0], 2'b00)
            bq = {ut(rsv[i]), 8'h00, 8'h00};
            xfer(1'b1, 1'b0);
            `CHK(acks[0], 1'b0)
        end
        page_wr(1'b0, 18);
        page_wr(1'b0, 1);
        bq = {ut(`SPDT_UT_SET1), 8'h00, 8'h00};
        xfer(1'b1, 1'b1);
        `CHK(acks[2:0], 3'b011)
        `CHK(protectFlags, 4'h0)
        hv = 1'b1;
        for (i = 0; i < 4; i++)
        begin
            bq = {ut(setc[i]), 8'h00, 8'h00};
            xfer(1'b1, 1'b1);
            `CHK(acks[2:0], 3'b111)
            `CHK(protectFlags, 4'((5'h2 << i) - 5'h1))
            for (k = 0; k < 4; k++)
            begin
                bq = {ut(qryc[k])};
                xfer(1'b1, 1'b0);
                `CHK(acks[0], 1'(k > i))
            end
        end
        bq = {ut(`SPDT_UT_SET0), 8'h00, 8'h00};
        xfer(1'b1, 1'b1);
        `CHK(acks[0], 1'b0)
        pStb = 0;
        bq = {adr(`SPDT_PRE_EEPROM, 1'b0), 8'h90, 8'h5a};
        xfer(1'b1, 1'b0);
        `CHK(eepromBusy, 1'b0)
        `CHK(pStb, 0)
        for (i = 0; i < 2; i++)
        begin
            hv = i[0];
            bq = {ut(`SPDT_UT_CLR), 8'h00, 8'h00};
            xfer(1'b1, 1'b1);
            `CHK(acks[2:0], {i[0], 2'b11})
            `CHK(protectFlags, i[0] ? 4'h0 : 4'hf)
        end
        for (i = 0; i < 2; i++)
        begin
            bq = {ut(i[0] ? `SPDT_UT_BANK0 : `SPDT_UT_BANK1), 8'h00, 8'h00};
            xfer(1'b1, 1'b1);
            `CHK(acks[2:0], 3'b011)
            `CHK(activeBank, 1'(i == 0))
            bq = {ut(`SPDT_UT_BANKQ)};
            xfer(1'b1, 1'b0);
            `CHK(acks[0], 1'(i == 1))
            if (i == 0)
                page_wr(1'b1, 1 + $unsigned($random(seed)) % 20);
        end
        stop_test();
    end
endmodule
`default_nettype wire
